// ===== rtl/acr_convert_read.v
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.vh"
// Function
// - a rising edge on start_conversion_n fires a 1 us internal start pulse.
// - a falling edge on start_conversion_n starts a conversion only once that pulse is low.
// - after a rising edge on start_conversion_n the device is powered within 1.3 us (13 clocks).
// - busy stays high through the conversion, which ends within 4.5 us, then falls.
// - busy rises no later than 300 ns (3 clocks) after the falling start edge.
// - result_bus is driven only while select and read are both low, else released.
// - at the end of conversion the start input level picks power-down or stay powered.
// - valid data appears within 300 ns (3 clocks) of read low while selected.
// - after supply comes up the device sits in power-down until a rising start edge.
module acr_convert_read
(
   input  wire                    clock,
   input  wire                    reset_n,
   input  wire                    start_conversion_n,
   input  wire                    select_n,
   input  wire                    read_n,
   input  wire [`ACR_DATA_W-1:0]  sample_in,
   output reg                     busy_ff,
   output reg                     powered_ff,
   output reg  [`ACR_DATA_W-1:0]  result_bus_o_ff,
   output reg  [`ACR_DATA_W-1:0]  result_bus_oe_ff
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg  [2:0]             conv_sync_ff;   // [0] first stage only feeds [1]
   reg  [1:0]             sel_sync_ff;
   reg  [1:0]             rd_sync_ff;
   wire                   conv_rise;
   wire                   conv_fall;
   wire                   read_on;

   // sample the pins; reset to high so a start pin held low through reset
   // gives at most a fall, which power-down ignores, never a false wake
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         conv_sync_ff <= 3'h7;
         sel_sync_ff  <= 2'h3;
         rd_sync_ff   <= 2'h3;
      end
      else
      begin
         conv_sync_ff <= {conv_sync_ff[1:0], start_conversion_n};
         sel_sync_ff  <= {sel_sync_ff[0], select_n};
         rd_sync_ff   <= {rd_sync_ff[0], read_n};
      end
   end

   // edges and read decode come from the settled stages only
   assign conv_rise = conv_sync_ff[1] & ~conv_sync_ff[2];
   assign conv_fall = ~conv_sync_ff[1] & conv_sync_ff[2];
   assign read_on   = ~sel_sync_ff[1] & ~rd_sync_ff[1];

   // ----------------------------------------
   // counter load values
   // ----------------------------------------
   // the cycle counts are integer expressions: hold them 32 bits wide and
   // take only the counter's bits where they meet the counters
   localparam [31:0]            WAKE_LOAD_W = `ACR_WAKE_CYC;
   localparam [31:0]            WAKE_DONE_W = `ACR_WAKE_CYC - `ACR_PWRUP_CYC + 1;
   localparam [31:0]            CONV_LOAD_W = `ACR_CONV_CYC - 1;
   localparam [`ACR_CNT_W-1:0]  WAKE_LOAD   = WAKE_LOAD_W[`ACR_CNT_W-1:0];
   localparam [`ACR_CNT_W-1:0]  WAKE_DONE   = WAKE_DONE_W[`ACR_CNT_W-1:0];
   localparam [`ACR_CNT_W-1:0]  CONV_LOAD   = CONV_LOAD_W[`ACR_CNT_W-1:0];

   // ----------------------------------------
   // control state machine
   // ----------------------------------------
   reg  [1:0]             state_ff;
   reg  [1:0]             nxt_state;
   reg  [`ACR_CNT_W-1:0]  pulse_cnt_ff;
   reg  [`ACR_CNT_W-1:0]  nxt_pulse_cnt;
   reg  [`ACR_CNT_W-1:0]  conv_cnt_ff;
   reg  [`ACR_CNT_W-1:0]  nxt_conv_cnt;
   reg                    nxt_busy;
   reg                    nxt_powered;
   reg                    push;
   wire                   pulse_high;
   wire                   buf_ready;
   wire                   buf_valid;
   wire [`ACR_DATA_W-1:0] buf_data;
   reg  [`ACR_DATA_W-1:0] hold_ff;

   // true once a down counter has run out; both counters use it
   function cnt_zero;
      input [`ACR_CNT_W-1:0] cnt;
      begin
         cnt_zero = (cnt == {`ACR_CNT_W{1'b0}});
      end
   endfunction

   // internal start pulse still running
   assign pulse_high = ~cnt_zero(pulse_cnt_ff);

   // next state, counters and busy
   always @*
   begin
      nxt_state     = state_ff;
      nxt_busy      = busy_ff;
      nxt_powered   = powered_ff;
      nxt_conv_cnt  = conv_cnt_ff;
      push          = 1'b0;
      nxt_pulse_cnt = pulse_high ? pulse_cnt_ff - 1'b1 : pulse_cnt_ff;
      // a rising edge restarts the pulse in every state, mid-conversion too
      if (conv_rise)
         nxt_pulse_cnt = WAKE_LOAD;
      case (state_ff)
         `ACR_ST_DOWN:
         begin
            if (conv_rise)
               nxt_state = `ACR_ST_WAKE;
         end
         `ACR_ST_WAKE:
         begin
            // internal pulse spans the power-up time
            if (pulse_cnt_ff == WAKE_DONE)
            begin
               nxt_state   = `ACR_ST_IDLE;
               nxt_powered = 1'b1;
            end
         end
         `ACR_ST_IDLE:
         begin
            if (conv_fall && !pulse_high)
            begin
               nxt_state    = `ACR_ST_CONV;
               nxt_busy     = 1'b1;
               nxt_conv_cnt = CONV_LOAD;
            end
         end
         `ACR_ST_CONV:
         begin
            if (!cnt_zero(conv_cnt_ff))
               nxt_conv_cnt = conv_cnt_ff - 1'b1;
            else if (buf_ready) // buffer back-pressure stalls completion
            begin
               push     = 1'b1;
               nxt_busy = 1'b0;
               // low start input at the end keeps power, high powers down
               if (conv_sync_ff[1])
               begin
                  nxt_state   = `ACR_ST_DOWN;
                  nxt_powered = 1'b0;
               end
               else
                  nxt_state = `ACR_ST_IDLE;
            end
         end
         default:
            nxt_state = `ACR_ST_DOWN;
      endcase
   end

   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff     <= `ACR_ST_DOWN;
         pulse_cnt_ff <= {`ACR_CNT_W{1'b0}};
         conv_cnt_ff  <= {`ACR_CNT_W{1'b0}};
         busy_ff      <= 1'b0;
         powered_ff   <= 1'b0;
      end
      else
      begin
         state_ff     <= nxt_state;
         pulse_cnt_ff <= nxt_pulse_cnt;
         conv_cnt_ff  <= nxt_conv_cnt;
         busy_ff      <= nxt_busy;
         powered_ff   <= nxt_powered;
      end
   end

   // ----------------------------------------
   // result buffer and read port
   // ----------------------------------------
   acr_result_buf u_buf
   (
      .clock       (clock),
      .reset_n     (reset_n),
      .in_valid    (push),
      .in_ready    (buf_ready),
      .in_data     (sample_in),
      .out_valid   (buf_valid),
      .out_ready   (1'b1),
      .out_data_ff (buf_data)
   );

   // latest result held between conversions
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         hold_ff <= 8'h00;
      else if (buf_valid)
         hold_ff <= buf_data;
   end

   // drive bus only during a selected read
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         result_bus_o_ff  <= 8'h00;
         result_bus_oe_ff <= 8'h00;
      end
      else
      begin
         result_bus_o_ff  <= hold_ff;
         result_bus_oe_ff <= {`ACR_DATA_W{read_on}};
      end
   end
endmodule // acr_convert_read
`default_nettype wire

// ===== rtl/acr_map.vh
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
// ----------------------------------------
// timing figures and derived cycle counts
// ----------------------------------------
`define ACR_CLK_NS           100
`define ACR_WAKE_PULSE_NS    1000
`define ACR_POWER_UP_NS      1000
`define ACR_CONV_NS          4500
// the pulse is a least time: round up
`define ACR_WAKE_CYC   ((`ACR_WAKE_PULSE_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
// power-up and conversion are longest times: round down
`define ACR_PWRUP_CYC  (`ACR_POWER_UP_NS / `ACR_CLK_NS)
`define ACR_CONV_CYC   (`ACR_CONV_NS / `ACR_CLK_NS)
`define ACR_CNT_W      6
`define ACR_DATA_W     8
`define ACR_BUF_DEPTH  2
// ----------------------------------------
// control states
// ----------------------------------------
`define ACR_ST_DOWN    2'h0
`define ACR_ST_WAKE    2'h1
`define ACR_ST_IDLE    2'h2
`define ACR_ST_CONV    2'h3
`endif

// ===== rtl/acr_result_buf.v
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.vh"
// two-entry buffer holding results between converter and read port
module acr_result_buf
(
   input  wire                    clock,
   input  wire                    reset_n,
   input  wire                    in_valid,
   output wire                    in_ready,
   input  wire [`ACR_DATA_W-1:0]  in_data,
   output wire                    out_valid,
   input  wire                    out_ready,
   output reg  [`ACR_DATA_W-1:0]  out_data_ff
);
   reg  [`ACR_DATA_W-1:0] mem_ff [0:`ACR_BUF_DEPTH-1];
   reg                    wr_ptr_ff;
   reg                    rd_ptr_ff;
   reg  [1:0]             count_ff;
   wire                   push;
   wire                   pop;
   wire                   nxt_rd_ptr;

   assign in_ready  = (count_ff != 2'h2);
   assign out_valid = (count_ff != 2'h0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign nxt_rd_ptr = pop ? ~rd_ptr_ff : rd_ptr_ff;

   // ----------------------------------------
   // storage, pointers and registered read data
   // ----------------------------------------
   always @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mem_ff[0]   <= 8'h00;
         mem_ff[1]   <= 8'h00;
         wr_ptr_ff   <= 1'b0;
         rd_ptr_ff   <= 1'b0;
         count_ff    <= 2'h0;
         out_data_ff <= 8'h00;
      end
      else
      begin
         if (push)
         begin
            mem_ff[wr_ptr_ff] <= in_data;
            wr_ptr_ff         <= ~wr_ptr_ff;
         end
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff  <= count_ff + {1'b0, push} - {1'b0, pop};
         // bypass so a word pushed into an empty buffer is seen next cycle
         if (push && (count_ff == 2'h0 || (count_ff == 2'h1 && pop)))
            out_data_ff <= in_data;
         else
            out_data_ff <= mem_ff[nxt_rd_ptr];
      end
   end
endmodule // acr_result_buf
`default_nettype wire

// ===== tb/acr_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the data bus: a released bus shows a changing pattern
module acr_bus_model
(
   input wire logic        clock,
   input wire logic [7:0]  drv_o,
   input wire logic [7:0]  drv_oe,
   output var logic [7:0]  result_bus
);
   logic [7:0] last_ff = 8'h00;
   // keep last level so a floating bit flips every cycle
   always_ff @(posedge clock) last_ff <= result_bus;
   assign result_bus = (drv_o & drv_oe) | (~last_ff & ~drv_oe);
endmodule // acr_bus_model
`default_nettype wire

// ===== tb/acr_convert_read_bench.sv
`timescale 1ns/1ps
`default_nettype none
module acr_convert_read_bench;
   logic       clock, reset_n, start_conversion_n, select_n, read_n, busy, powered;
   logic [7:0] sample_in, result_bus_o, result_bus_oe, result_bus, v;
   logic [7:0] oe_d = 8'h00;
   logic [7:0] exp_q[$];
   integer     error_cnt = 0, comparisons = 0, cycles = 0, seed = 32'h58ff, i, n;
   acr_convert_read dut (.clock(clock), .reset_n(reset_n), .start_conversion_n(start_conversion_n),
      .select_n(select_n), .read_n(read_n), .sample_in(sample_in), .busy_ff(busy),
      .powered_ff(powered), .result_bus_o_ff(result_bus_o), .result_bus_oe_ff(result_bus_oe));
   acr_bus_model host (.clock(clock), .drv_o(result_bus_o), .drv_oe(result_bus_oe),
      .result_bus(result_bus));
   task cyc(input integer k); repeat (k) @(negedge clock); endtask
   task check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // a fall right after a rise must start nothing
   task refuse;
      start_conversion_n = 1'b1; cyc(3); start_conversion_n = 1'b0; cyc(6);
      check({7'h0, busy}, 8'h00);
   endtask
   // rise wakes the part; the long wait also covers acquisition
   task wake;
      start_conversion_n = 1'b0; cyc(2); start_conversion_n = 1'b1; cyc(14);
      check({7'h0, powered}, 8'h01);
   endtask
   task convert(input logic stay);
      sample_in = v; start_conversion_n = 1'b0; cyc(4);
      check({7'h0, busy}, 8'h01);
      if (!stay) start_conversion_n = 1'b1;
      n = 0;
      while (busy === 1'b1 && n < 60) begin cyc(1); n++; end
      check(8'(n + 1), 8'h2d);
      cyc(8);
      check({6'h0, busy, powered}, {7'h0, stay});
   endtask
   // one bus read; the monitor compares the word
   task read_word;
      exp_q.push_back(v);
      select_n = 1'b0; read_n = 1'b0; cyc(5); select_n = 1'b1; read_n = 1'b1; cyc(5);
      check(result_bus_oe, 8'h00);
   endtask
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // compare the bus when the device starts driving it
   always @(negedge clock)
   begin
      if (result_bus_oe === 8'hff && oe_d !== 8'hff && exp_q.size() > 0)
         check(result_bus, exp_q.pop_front());
      oe_d = result_bus_oe;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 2000) begin error_cnt++; print_verdict; end
   end
   initial
   begin
      reset_n = 1'b0; start_conversion_n = 1'b0; select_n = 1'b1; read_n = 1'b1;
      sample_in = 8'h00;
      cyc(2); reset_n = 1'b1; cyc(5);
      check({6'h0, busy, powered}, 8'h00);
      refuse;
      $display("test 1 done");
      for (i = 0; i < 4; i++)
      begin
         v = 8'($random(seed));
         wake;
         convert(i[0]);
         read_word; read_word;
         $display("test %0d done", i + 2);
      end
      refuse;
      check(8'(exp_q.size()), 8'h00);
      $display("test 6 done");
      print_verdict;
   end
endmodule // acr_convert_read_bench
bind acr_convert_read acr_convert_read_properties u_props (.clock(clock), .reset_n(reset_n),
   .start_conversion_n(start_conversion_n), .select_n(select_n), .read_n(read_n),
   .sample_in(sample_in), .busy_ff(busy_ff), .powered_ff(powered_ff),
   .result_bus_o_ff(result_bus_o_ff), .result_bus_oe_ff(result_bus_oe_ff));
`default_nettype wire

// ===== tb/acr_convert_read_properties.sv
`timescale 1ns/1ps
`default_nettype none
module acr_convert_read_properties
(
   input wire logic       clock,
   input wire logic       reset_n,
   input wire logic       start_conversion_n,
   input wire logic       select_n,
   input wire logic       read_n,
   input wire logic [7:0] sample_in,
   input wire logic       busy_ff,
   input wire logic       powered_ff,
   input wire logic [7:0] result_bus_o_ff,
   input wire logic [7:0] result_bus_oe_ff
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic [5:0] busy_cnt_ff;
   // counts cycles of one busy period
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n) busy_cnt_ff <= 6'h00;
      else busy_cnt_ff <= busy_ff ? busy_cnt_ff + 6'h01 : 6'h00;
   end
   busy_length_a: assert property ($fell(busy_ff) |-> busy_cnt_ff == 6'h2d)
      else $error("busy period length wrong");
   busy_bound_a: assert property (busy_cnt_ff <= 6'h2d)
      else $error("busy period too long");
   busy_cause_a: assert property ($rose(busy_ff) |-> powered_ff && !$past(start_conversion_n, 3))
      else $error("busy rose without start");
   wake_time_a: assert property ($rose(start_conversion_n) |-> ##[1:13] powered_ff)
      else $error("power-up too slow");
   wake_cause_a: assert property ($rose(powered_ff) |-> $past(start_conversion_n, 13) && !$past(start_conversion_n, 14))
      else $error("powered without wake edge");
   power_down_a: assert property ($fell(busy_ff) && $past(start_conversion_n, 3) |-> !powered_ff)
      else $error("no power-down after conversion");
   stay_up_a: assert property ($fell(busy_ff) && !$past(start_conversion_n, 3) |-> powered_ff [*6])
      else $error("powered down while start low");
   bus_off_a: assert property ((select_n || read_n) [*4] |=> result_bus_oe_ff == 8'h00)
      else $error("bus driven while not read");
   bus_on_a: assert property ((!select_n && !read_n) [*4] |=> result_bus_oe_ff == 8'hff)
      else $error("bus not driven during read");
   result_hold_a: assert property ((!busy_ff) [*8] |=> $stable(result_bus_o_ff))
      else $error("result changed while idle");
endmodule // acr_convert_read_properties
`default_nettype wire
